// ==== rx_audio_clock_infoframe_regs.sv ====
// Register slice of a video and audio link receiver: audio clock control,
// pad control, packet flags, channel status and video frame fields.
// Assumes all inputs synchronous to clk_i and pulses one cycle long.
//
// Functional notes
// - Regeneration block bit stops received packets updating time stamp, divider.
// - Master clock multiple code selects (code plus one) times 128 fs.
// - Pull-up off bit disables internal pull-ups on EEPROM serial lines.
// - Termination override: 0 automatic, 1 manual termination bit controls.
// - Manual termination bit: 0 terminated normally, 1 disconnected.
// - Underflow auto-reset bit resets audio FIFO on detected underflow.
// - Overflow auto-reset bit resets audio FIFO on detected overflow.
// - High-impedance bit releases EEPROM serial lines for in-circuit programming.
// - Packet flags set on reception; cleared only by reset or clock loss.
// - Flag bits: video, audio, source product, MPEG, protection, codes one, two.
// - Time stamp bits 19-12, 11-4, then 3-0 in third upper nibble.
// - Divider bits 19-16 in lower nibble of the third register.
// - Pixel encoding 00 RGB, 01 YCbCr 4:2:2, 10 YCbCr 4:4:4.
// - Active format present bit is 1 when format data valid.
// - Bar field 00 none, 01 horizontal, 10 vertical, 11 both.
// - Active format ratio 8 same, 9 4:3, A 16:9, B 14:9.
`timescale 1ns/100ps
module rx_audio_clock_infoframe_regs (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        reg_read_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        loss_of_clock_i,
   input  wire logic [6:0]  packet_received_i,
   input  wire logic        link_mode_i,
   input  wire logic        regen_valid_i,
   input  wire logic [19:0] regen_cts_i,
   input  wire logic [19:0] regen_n_i,
   input  wire logic        channel_status_valid_i,
   input  wire logic [7:0]  channel_status_byte0_i,
   input  wire logic [7:0]  channel_status_category_i,
   input  wire logic [7:0]  channel_status_numbers_i,
   input  wire logic [7:0]  channel_status_rate_i,
   input  wire logic [3:0]  channel_status_word_length_i,
   input  wire logic        video_info_frame_valid_i,
   input  wire logic [7:0]  video_frame_version_i,
   input  wire logic [6:0]  video_frame_format_i,
   input  wire logic [7:0]  video_frame_aspect_i,
   input  wire logic [1:0]  video_frame_scaling_i,
   input  wire logic        fifo_underflow_i,
   input  wire logic        fifo_overflow_i,
   input  wire logic        auto_term_connect_i,
   output logic      [2:0]  master_clock_multiple_o,
   output logic      [10:0] mclk_fs_multiple_o,
   output logic      [11:0] sample_rate_o,
   output logic             serial_line_pullup_en_o,
   output logic             eeprom_serial_lines_oe_n_o,
   output logic             clock_term_connect_o,
   output logic             audio_fifo_reset_o,
   output logic             irq_o
);
   typedef struct packed {
      logic [7:0]  audio_ctl;
      logic [7:0]  pad_ctl;
      logic        link_mode;
      logic [7:0]  cs_byte0;
      logic [7:0]  cs_category;
      logic [7:0]  cs_numbers;
      logic [7:0]  cs_rate;
      logic [3:0]  cs_word_length;
      logic [19:0] cts;
      logic [3:0]  n_high;
      logic [7:0]  avi_version;
      logic [6:0]  avi_format;
      logic [7:0]  avi_aspect;
      logic [1:0]  avi_scaling;
      logic [4:0]  ev_mask;
      logic [7:0]  rdata;
      logic [2:0]  mclk_code;
      logic [10:0] mclk_mult;
      logic [11:0] rate;
      logic        pullup_en;
      logic        lines_oe_n;
      logic        term_connect;
      logic        fifo_reset;
      logic        irq;
   } state_type;

   state_type state;
   state_type next_state;

   logic [6:0] packet_flags;
   logic [4:0] ev_flags;
   logic [4:0] ev_set;
   logic [4:0] ev_clear;
   logic       wr_status;

   assign wr_status = reg_write_i &&
                      reg_addr_i == rx_regs_pkg::event_status_addr;
   assign ev_clear  = wr_status ? reg_wdata_i[4:0] : 5'h00;

   always_comb begin
      ev_set = 5'h00;
      ev_set[rx_regs_pkg::ev_packet_bit]    = |(packet_received_i
                                                & ~packet_flags);
      ev_set[rx_regs_pkg::ev_underflow_bit] = fifo_underflow_i;
      ev_set[rx_regs_pkg::ev_overflow_bit]  = fifo_overflow_i;
      ev_set[rx_regs_pkg::ev_regen_bit]     = regen_valid_i;
      ev_set[rx_regs_pkg::ev_mode_bit]      = link_mode_i != state.link_mode;
   end

   // Bit positions follow the packet kinds on packet_received_i.
   sticky_flags #(
      .width (rx_regs_pkg::packet_kind_count)
   ) packet_seen (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .set_i       (packet_received_i),
      .clear_i     (7'h00),
      .clear_all_i (loss_of_clock_i),
      .flags_o     (packet_flags)
   );

   sticky_flags #(
      .width (rx_regs_pkg::event_count)
   ) event_status (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .set_i       (ev_set),
      .clear_i     (ev_clear),
      .clear_all_i (1'b0),
      .flags_o     (ev_flags)
   );

   always_comb begin
      next_state = state;
      next_state.link_mode = link_mode_i;

      // Register writes.
      if (reg_write_i) begin
         case (reg_addr_i)
            rx_regs_pkg::audio_clock_control_addr: begin
               next_state.audio_ctl = reg_wdata_i;
            end
            rx_regs_pkg::link_pad_fifo_control_addr: begin
               next_state.pad_ctl = reg_wdata_i;
            end
            rx_regs_pkg::time_stamp_high_addr: begin
               next_state.cts[19:12] = reg_wdata_i;
            end
            rx_regs_pkg::time_stamp_mid_addr: begin
               next_state.cts[11:4] = reg_wdata_i;
            end
            rx_regs_pkg::time_stamp_low_divider_high_addr: begin
               next_state.cts[3:0] = reg_wdata_i[7:4];
               next_state.n_high   = reg_wdata_i[3:0];
            end
            rx_regs_pkg::event_mask_addr: begin
               next_state.ev_mask = reg_wdata_i[4:0];
            end
            default: begin
            end
         endcase
      end

      // Received packets win over a software write in the same cycle.
      if (regen_valid_i &&
          !state.audio_ctl[rx_regs_pkg::regen_block_bit]) begin
         next_state.cts    = regen_cts_i;
         next_state.n_high = regen_n_i[19:16];
      end

      if (channel_status_valid_i) begin
         next_state.cs_byte0       = channel_status_byte0_i;
         next_state.cs_category    = channel_status_category_i;
         next_state.cs_numbers     = channel_status_numbers_i;
         next_state.cs_rate        = {2'b00, channel_status_rate_i[5:0]};
         next_state.cs_word_length = channel_status_word_length_i;
      end

      if (video_info_frame_valid_i) begin
         next_state.avi_version = video_frame_version_i;
         // Encoding 6-5, format present 4, bars 3-2.
         next_state.avi_format  = video_frame_format_i;
         // Ratio field 3-0 carries the active format codes.
         next_state.avi_aspect  = video_frame_aspect_i;
         next_state.avi_scaling = video_frame_scaling_i;
      end

      // Register reads, data in the following cycle.
      next_state.rdata = 8'h00;
      if (reg_read_i) begin
         case (reg_addr_i)
            rx_regs_pkg::audio_clock_control_addr: begin
               next_state.rdata = state.audio_ctl;
            end
            rx_regs_pkg::link_pad_fifo_control_addr: begin
               next_state.rdata = state.pad_ctl;
            end
            rx_regs_pkg::packet_seen_flags_addr: begin
               next_state.rdata = {1'b0, packet_flags};
            end
            rx_regs_pkg::link_mode_status_addr: begin
               next_state.rdata = 8'h00;
               next_state.rdata[rx_regs_pkg::link_mode_bit] =
                  state.link_mode;
            end
            rx_regs_pkg::channel_status_byte0_addr: begin
               next_state.rdata = state.cs_byte0;
            end
            rx_regs_pkg::channel_status_category_addr: begin
               next_state.rdata = state.cs_category;
            end
            rx_regs_pkg::channel_status_numbers_addr: begin
               next_state.rdata = state.cs_numbers;
            end
            rx_regs_pkg::channel_status_rate_addr: begin
               next_state.rdata = state.cs_rate;
            end
            rx_regs_pkg::channel_status_word_length_addr: begin
               next_state.rdata = {4'h0, state.cs_word_length};
            end
            rx_regs_pkg::time_stamp_high_addr: begin
               next_state.rdata = state.cts[19:12];
            end
            rx_regs_pkg::time_stamp_mid_addr: begin
               next_state.rdata = state.cts[11:4];
            end
            rx_regs_pkg::time_stamp_low_divider_high_addr: begin
               next_state.rdata = {state.cts[3:0], state.n_high};
            end
            rx_regs_pkg::video_frame_version_addr: begin
               next_state.rdata = state.avi_version;
            end
            rx_regs_pkg::video_frame_format_addr: begin
               next_state.rdata = {1'b0, state.avi_format};
            end
            rx_regs_pkg::video_frame_aspect_addr: begin
               next_state.rdata = state.avi_aspect;
            end
            rx_regs_pkg::video_frame_scaling_addr: begin
               next_state.rdata = {6'h00, state.avi_scaling};
            end
            rx_regs_pkg::event_status_addr: begin
               next_state.rdata = {3'h0, ev_flags};
            end
            rx_regs_pkg::event_mask_addr: begin
               next_state.rdata = {3'h0, state.ev_mask};
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end

      // Master clock multiple from the control code.
      next_state.mclk_code = state.audio_ctl[2:0];
      next_state.mclk_mult = 11'({8'h00, state.audio_ctl[2:0]} + 11'h001)
                             * rx_regs_pkg::mclk_unit_fs;

      // Sampling frequency decode of the channel status rate field.
      case (state.cs_rate[3:0])
         rx_regs_pkg::fs_44k1: next_state.rate = rx_regs_pkg::rate_44k1;
         rx_regs_pkg::fs_48k: next_state.rate = rx_regs_pkg::rate_48k;
         rx_regs_pkg::fs_32k: next_state.rate = rx_regs_pkg::rate_32k;
         rx_regs_pkg::fs_88k2: next_state.rate = rx_regs_pkg::rate_88k2;
         rx_regs_pkg::fs_96k: next_state.rate = rx_regs_pkg::rate_96k;
         rx_regs_pkg::fs_176k4: next_state.rate = rx_regs_pkg::rate_176k4;
         rx_regs_pkg::fs_192k: next_state.rate = rx_regs_pkg::rate_192k;
         default: next_state.rate = rx_regs_pkg::rate_none;
      endcase

      // Pad control.
      next_state.pullup_en  =
         !state.pad_ctl[rx_regs_pkg::pullup_off_bit];
      next_state.lines_oe_n =
         state.pad_ctl[rx_regs_pkg::high_z_bit];
      if (state.pad_ctl[rx_regs_pkg::term_override_bit]) begin
         next_state.term_connect =
            !state.pad_ctl[rx_regs_pkg::term_manual_bit];
      end else begin
         next_state.term_connect = auto_term_connect_i;
      end

      // Audio FIFO auto-reset.
      next_state.fifo_reset =
         (fifo_underflow_i &&
          state.pad_ctl[rx_regs_pkg::underflow_rst_bit]) ||
         (fifo_overflow_i &&
          state.pad_ctl[rx_regs_pkg::overflow_rst_bit]);

      next_state.irq = |(ev_flags & state.ev_mask);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state              <= '0;
         state.pullup_en    <= 1'b1;
         state.term_connect <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata_o                = state.rdata;
   assign master_clock_multiple_o    = state.mclk_code;
   assign mclk_fs_multiple_o         = state.mclk_mult;
   assign sample_rate_o              = state.rate;
   assign serial_line_pullup_en_o    = state.pullup_en;
   assign eeprom_serial_lines_oe_n_o = state.lines_oe_n;
   assign clock_term_connect_o       = state.term_connect;
   assign audio_fifo_reset_o         = state.fifo_reset;
   assign irq_o                      = state.irq;
endmodule

// ==== rx_regs_pkg.sv ====
// Package with register offsets, field positions and reset values of the
// receiver audio clock and frame register slice.
// Assumes an 8-bit register port with byte-wide registers.
package rx_regs_pkg;
   localparam logic [7:0] audio_clock_control_addr        = 8'h58;
   localparam logic [7:0] link_pad_fifo_control_addr      = 8'h59;
   localparam logic [7:0] packet_seen_flags_addr          = 8'h5a;
   localparam logic [7:0] link_mode_status_addr           = 8'h5b;
   localparam logic [7:0] channel_status_byte0_addr       = 8'h5e;
   localparam logic [7:0] channel_status_category_addr    = 8'h5f;
   localparam logic [7:0] channel_status_numbers_addr     = 8'h60;
   localparam logic [7:0] channel_status_rate_addr        = 8'h61;
   localparam logic [7:0] channel_status_word_length_addr = 8'h62;
   localparam logic [7:0] time_stamp_high_addr            = 8'h7b;
   localparam logic [7:0] time_stamp_mid_addr             = 8'h7c;
   localparam logic [7:0] time_stamp_low_divider_high_addr = 8'h7d;
   localparam logic [7:0] video_frame_version_addr        = 8'h80;
   localparam logic [7:0] video_frame_format_addr         = 8'h81;
   localparam logic [7:0] video_frame_aspect_addr         = 8'h82;
   localparam logic [7:0] video_frame_scaling_addr        = 8'h83;
   localparam logic [7:0] event_status_addr               = 8'hf0;
   localparam logic [7:0] event_mask_addr                 = 8'hf1;

   // Audio clock control fields.
   localparam int regen_block_bit    = 3;
   localparam int mclk_multiple_lsb  = 0;
   // Pad and FIFO control fields.
   localparam int pullup_off_bit     = 6;
   localparam int term_override_bit  = 5;
   localparam int term_manual_bit    = 4;
   localparam int underflow_rst_bit  = 2;
   localparam int overflow_rst_bit   = 1;
   localparam int high_z_bit         = 0;
   // Link mode status field.
   localparam int link_mode_bit      = 3;

   // Event status bits.
   localparam int ev_packet_bit      = 0;
   localparam int ev_underflow_bit   = 1;
   localparam int ev_overflow_bit    = 2;
   localparam int ev_regen_bit       = 3;
   localparam int ev_mode_bit        = 4;
   localparam int event_count        = 5;
   localparam int packet_kind_count  = 7;

   localparam logic [7:0]  control_reset    = 8'h00;
   localparam logic [7:0]  status_reset     = 8'h00;
   localparam logic [10:0] mclk_unit_fs     = 11'h080;

   // Sampling frequency codes and rates in units of 100 Hz.
   localparam logic [3:0]  fs_44k1 = 4'h0;
   localparam logic [3:0]  fs_48k  = 4'h2;
   localparam logic [3:0]  fs_32k  = 4'h3;
   localparam logic [3:0]  fs_88k2 = 4'h8;
   localparam logic [3:0]  fs_96k  = 4'ha;
   localparam logic [3:0]  fs_176k4 = 4'hc;
   localparam logic [3:0]  fs_192k = 4'he;
   localparam logic [11:0] rate_44k1 = 12'h1b9;
   localparam logic [11:0] rate_48k  = 12'h1e0;
   localparam logic [11:0] rate_32k  = 12'h140;
   localparam logic [11:0] rate_88k2 = 12'h372;
   localparam logic [11:0] rate_96k  = 12'h3c0;
   localparam logic [11:0] rate_176k4 = 12'h6e4;
   localparam logic [11:0] rate_192k = 12'h780;
   localparam logic [11:0] rate_none = 12'h000;
endpackage

// ==== sticky_flags.sv ====
// Bank of sticky flags: set by hardware pulses, cleared by a write of ones
// or all at once by a clear pulse.
// Assumes set and clear inputs synchronous to clk_i.
`timescale 1ns/100ps
module sticky_flags #(
   parameter int width = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [width-1:0] set_i,
   input  wire logic [width-1:0] clear_i,
   input  wire logic             clear_all_i,
   output logic      [width-1:0] flags_o
);
   typedef struct packed {
      logic [width-1:0] flags;
   } flag_state_type;

   flag_state_type state;
   flag_state_type next_state;

   always_comb begin
      next_state = state;
      if (clear_all_i) begin
         next_state.flags = '0;
      end else begin
         // A set arriving with its clear keeps the flag.
         next_state.flags = (state.flags & ~clear_i) | set_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flags_o = state.flags;
endmodule

// ==== rx_link_source_model.sv ====
// Behavioural model of the video source transmitter feeding the receiver.
// Assumes the bench calls its tasks and clk_i is the receiver link clock.
`timescale 1ns/100ps
module rx_link_source_model (
   input  wire logic        clk_i,
   output logic      [6:0]  packet_o,
   output logic             mode_o,
   output logic             regen_o,
   output logic      [19:0] cts_o,
   output logic      [19:0] n_o,
   output logic             cs_o,
   output logic      [35:0] cs_d_o,
   output logic             vf_o,
   output logic      [24:0] vf_d_o
);
   initial begin
      {packet_o, mode_o, regen_o, cs_o, vf_o} = '0;
      {cts_o, n_o, cs_d_o, vf_d_o} = '1;
   end
   // Payloads are inverted once their one-cycle valid pulse has ended.
   task automatic regen(input logic [19:0] c, input logic [19:0] n);
      @(posedge clk_i);
      {regen_o, cts_o, n_o} <= {1'b1, c, n};
      @(posedge clk_i);
      {regen_o, cts_o, n_o} <= {1'b0, ~c, ~n};
   endtask
   task automatic cstat(input logic [35:0] d);
      @(posedge clk_i);
      {cs_o, cs_d_o} <= {1'b1, d};
      @(posedge clk_i);
      {cs_o, cs_d_o} <= {1'b0, ~d};
   endtask
   task automatic vframe(input logic [24:0] d);
      @(posedge clk_i);
      {vf_o, vf_d_o} <= {1'b1, d};
      @(posedge clk_i);
      {vf_o, vf_d_o} <= {1'b0, ~d};
   endtask
   task automatic packet(input int k);
      @(posedge clk_i);
      packet_o <= 7'h01 << k;
      @(posedge clk_i);
      packet_o <= 7'h00;
   endtask
   task automatic mode(input logic m);
      @(posedge clk_i);
      mode_o <= m;
   endtask
endmodule

// ==== rx_audio_clock_infoframe_regs_checker.sv ====
// Concurrent checks on the ports of the receiver register slice.
// Assumes one clock domain and the register port timing of the slice.
`timescale 1ns/100ps
module rx_regs_checker (
   input logic        clk_i,
   input logic        rst_n_i,
   input logic [7:0]  reg_addr_i,
   input logic [7:0]  reg_wdata_i,
   input logic        reg_write_i,
   input logic        reg_read_i,
   input logic [7:0]  reg_rdata_o,
   input logic        loss_of_clock_i,
   input logic        regen_valid_i,
   input logic        channel_status_valid_i,
   input logic [7:0]  channel_status_rate_i,
   input logic        fifo_underflow_i,
   input logic        fifo_overflow_i,
   input logic [10:0] mclk_fs_multiple_o,
   input logic [11:0] sample_rate_o,
   input logic        serial_line_pullup_en_o,
   input logic        eeprom_serial_lines_oe_n_o,
   input logic        clock_term_connect_o,
   input logic        audio_fifo_reset_o,
   input logic        irq_o
);
   logic [7:0] wd1;
   logic [7:0] wd2;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Write data delayed to line up with the derived outputs.
   always_ff @(posedge clk_i) begin
      wd1 <= reg_wdata_i;
      wd2 <= wd1;
   end
   property p_mclk;
      reg_write_i && reg_addr_i == 8'h58 |-> ##2
         mclk_fs_multiple_o == (11'(wd2[2:0]) + 11'h001) << 7;
   endproperty
   property p_pullup;
      reg_write_i && reg_addr_i == 8'h59 |-> ##2
         serial_line_pullup_en_o == !wd2[6];
   endproperty
   property p_high_z;
      reg_write_i && reg_addr_i == 8'h59 |-> ##2
         eeprom_serial_lines_oe_n_o == wd2[0];
   endproperty
   property p_term;
      reg_write_i && reg_addr_i == 8'h59 && reg_wdata_i[5] |-> ##2
         clock_term_connect_o == !wd2[4];
   endproperty
   property p_fifo;
      audio_fifo_reset_o |-> $past(fifo_underflow_i) || $past(fifo_overflow_i);
   endproperty
   property p_flags;
      loss_of_clock_i ##1 (reg_read_i && reg_addr_i == 8'h5a)
         |=> reg_rdata_o == 8'h00;
   endproperty
   property p_rate;
      channel_status_valid_i && channel_status_rate_i[3:0] == 4'h2
         |-> ##2 sample_rate_o == 12'h1e0;
   endproperty
   property p_mode;
      reg_read_i && reg_addr_i == 8'h5b
         |=> {reg_rdata_o[7:4], reg_rdata_o[2:0]} == 7'h00;
   endproperty
   a_mclk: assert property (p_mclk) else $error("mclk multiple wrong");
   a_pullup: assert property (p_pullup) else $error("pull-up wrong");
   a_high_z: assert property (p_high_z) else $error("high-z wrong");
   a_term: assert property (p_term) else $error("termination wrong");
   a_fifo: assert property (p_fifo) else $error("fifo reset uncaused");
   a_flags: assert property (p_flags) else $error("flags not cleared");
   a_rate: assert property (p_rate) else $error("sample rate wrong");
   a_mode: assert property (p_mode) else $error("mode reserved bits");
   cover property (audio_fifo_reset_o);
   cover property (regen_valid_i ##2 irq_o);
   cover property (loss_of_clock_i ##1 reg_read_i);
endmodule
bind rx_audio_clock_infoframe_regs rx_regs_checker u_checker (.*);

// ==== rx_audio_clock_infoframe_regs_tb.sv ====
// Self-checking bench of the receiver register slice with a link source.
// Assumes the bench alone drives the register port and pad inputs.
`timescale 1ns/100ps
module rx_audio_clock_infoframe_regs_tb;
   logic        clk_i, rst_n_i, reg_write_i, reg_read_i, loss_of_clock_i;
   logic        fifo_underflow_i, fifo_overflow_i, auto_term_connect_i;
   logic [7:0]  reg_addr_i, reg_wdata_i;
   wire  [7:0]  reg_rdata_o;
   wire  [6:0]  packet_received_i, video_frame_format_i;
   wire         link_mode_i, regen_valid_i, channel_status_valid_i;
   wire         video_info_frame_valid_i, irq_o, audio_fifo_reset_o;
   wire  [19:0] regen_cts_i, regen_n_i;
   wire  [7:0]  channel_status_byte0_i, channel_status_category_i;
   wire  [7:0]  channel_status_numbers_i, channel_status_rate_i;
   wire  [3:0]  channel_status_word_length_i;
   wire  [7:0]  video_frame_version_i, video_frame_aspect_i;
   wire  [1:0]  video_frame_scaling_i;
   wire  [2:0]  master_clock_multiple_o;
   wire  [10:0] mclk_fs_multiple_o;
   wire  [11:0] sample_rate_o;
   wire         serial_line_pullup_en_o, eeprom_serial_lines_oe_n_o;
   wire         clock_term_connect_o;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   rx_audio_clock_infoframe_regs DUT (.*);
   rx_link_source_model src (
      .clk_i, .packet_o(packet_received_i), .mode_o(link_mode_i),
      .regen_o(regen_valid_i), .cts_o(regen_cts_i), .n_o(regen_n_i),
      .cs_o(channel_status_valid_i),
      .cs_d_o({channel_status_byte0_i, channel_status_category_i,
               channel_status_numbers_i, channel_status_rate_i,
               channel_status_word_length_i}),
      .vf_o(video_info_frame_valid_i),
      .vf_d_o({video_frame_version_i, video_frame_format_i,
               video_frame_aspect_i, video_frame_scaling_i}));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      {reg_addr_i, reg_read_i} <= {a, 1'b1};
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 cmp(12'(reg_rdata_o), 12'(e));
   endtask
   // Waits out the lag of the derived outputs.
   task automatic settle;
      @(posedge clk_i);
      #1;
   endtask
   task automatic t_reset;
      cmp(12'({serial_line_pullup_en_o, clock_term_connect_o}), 12'h3);
      cmp(12'({eeprom_serial_lines_oe_n_o, audio_fifo_reset_o, irq_o}), 12'h0);
      rd_chk(8'h58, 8'h00);
      rd_chk(8'h59, 8'h00);
      rd_chk(8'h70, 8'h00);
      wr(8'h70, 8'hff);
      wr(8'h5a, 8'h7f);
      rd_chk(8'h5a, 8'h00);
   endtask
   task automatic t_regen;
      wr(8'hf1, 8'h08);
      src.regen(20'habcde, 20'h51234);
      settle();
      cmp(12'(irq_o), 12'h1);
      rd_chk(8'h7b, 8'hab);
      rd_chk(8'h7c, 8'hcd);
      rd_chk(8'h7d, 8'he5);
      wr(8'hf0, 8'h08);
      settle();
      cmp(12'(irq_o), 12'h0);
      wr(8'h58, 8'h08);
      src.regen(20'h13579, 20'h2468a);
      rd_chk(8'h7b, 8'hab);
      rd_chk(8'h7d, 8'he5);
      rd_chk(8'hf0, 8'h08);
      wr(8'hf1, 8'h00);
      settle();
      cmp(12'(irq_o), 12'h0);
      wr(8'hf0, 8'h08);
   endtask
   task automatic t_mclk;
      for (int c = 0; c < 8; c++) begin
         wr(8'h58, 8'(c));
         settle();
         cmp(12'(master_clock_multiple_o), 12'(c));
         cmp(12'(mclk_fs_multiple_o), 12'((c + 1) * 128));
      end
   endtask
   task automatic t_pads;
      logic [7:0] d [6] = '{8'h00, 8'h00, 8'h40, 8'h01, 8'h20, 8'h30};
      logic [3:0] e [6] = '{4'hd, 4'h4, 4'h9, 4'hf, 4'h5, 4'hc};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         auto_term_connect_i <= e[i][3];
         wr(8'h59, d[i]);
         settle();
         cmp(12'({serial_line_pullup_en_o, eeprom_serial_lines_oe_n_o,
                  clock_term_connect_o}), 12'(e[i][2:0]));
      end
   endtask
   task automatic t_fifo;
      for (int i = 0; i < 4; i++) begin
         wr(8'h59, i[1] ? 8'h02 : 8'h04);
         @(posedge clk_i);
         {fifo_underflow_i, fifo_overflow_i} <= {!i[0], i[0]};
         @(posedge clk_i);
         {fifo_underflow_i, fifo_overflow_i} <= 2'b00;
         #1 cmp(12'(audio_fifo_reset_o), 12'(i[1] == i[0]));
         settle();
         cmp(12'(audio_fifo_reset_o), 12'h0);
      end
   endtask
   task automatic t_flags;
      logic [7:0] m = 8'h00;
      for (int k = 0; k < 7; k++) begin
         src.packet(k);
         m[k] = 1'b1;
         rd_chk(8'h5a, m);
      end
      @(posedge clk_i);
      loss_of_clock_i <= 1'b1;
      @(posedge clk_i);
      {loss_of_clock_i, reg_addr_i, reg_read_i} <= {1'b0, 8'h5a, 1'b1};
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 cmp(12'(reg_rdata_o), 12'h0);
   endtask
   task automatic t_cstat;
      logic [3:0]  c [8] = '{4'h0, 4'h2, 4'h3, 4'h8, 4'ha, 4'hc, 4'he, 4'h1};
      logic [11:0] r [8] = '{12'h1b9, 12'h1e0, 12'h140, 12'h372, 12'h3c0,
                             12'h6e4, 12'h780, 12'h000};
      for (int i = 0; i < 8; i++) begin
         src.cstat({8'h5a, 8'h3c, 8'ha5, 4'hd, c[i], 4'h9});
         settle();
         cmp(sample_rate_o, r[i]);
         rd_chk(8'h61, {4'h1, c[i]});
      end
      rd_chk(8'h5e, 8'h5a);
      rd_chk(8'h5f, 8'h3c);
      rd_chk(8'h60, 8'ha5);
      rd_chk(8'h62, 8'h09);
   endtask
   task automatic t_video;
      logic [6:0] f;
      logic [7:0] a;
      for (int i = 0; i < 4; i++) begin
         f = {2'(i % 3), i[0], 2'(i), 2'(3 - i)};
         a = {2'(i), 2'(i), 4'h8 + 4'(i)};
         src.vframe({8'h02, f, a, 2'(i)});
         rd_chk(8'h81, {1'b0, f});
         rd_chk(8'h82, a);
         rd_chk(8'h83, {6'h00, 2'(i)});
      end
      rd_chk(8'h80, 8'h02);
   endtask
   task automatic t_mode;
      src.mode(1'b1);
      rd_chk(8'h5b, 8'h08);
      src.mode(1'b0);
      rd_chk(8'h5b, 8'h00);
   endtask
   initial begin
      {reg_write_i, reg_read_i, loss_of_clock_i} = 3'b000;
      {fifo_underflow_i, fifo_overflow_i} = 2'b00;
      {reg_addr_i, reg_wdata_i} = 16'h0000;
      auto_term_connect_i = 1'b1;
      rst_n_i = 1'b0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1 t_reset();
      t_regen();
      t_mclk();
      t_pads();
      t_fifo();
      t_flags();
      t_cstat();
      t_video();
      t_mode();
      final_report();
   end
endmodule
